// >>> rtl/vps_supervisor.sv
// valve position supervisor: shutoff saturation, clamps, travel, cycles, alarms, apb registers
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "vps_defs.svh"

module vps_supervisor #(
   parameter int TICK_CYC = `VPS_TICK_NS / `VPS_CLK_NS,
   parameter int STEP_CYC = `VPS_STEP_NS / `VPS_CLK_NS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire vps_pkg::vps_sense_t sense,
   output var vps_pkg::vps_drive_t drive,
   output var vps_pkg::vps_led_t led
);
   import vps_pkg::*;

   function automatic logic [15:0] cfg_sum(input logic [`VPS_NCFG-1:0][15:0] c);
      logic [15:0] s;
      s = 16'h0000;
      for (int i = 0; i < `VPS_NCFG; i++)
         s = s + c[i];
      return s;
   endfunction

   localparam logic [`VPS_NCFG-1:0][15:0] CFG_RST = `VPS_CFG_RST;
   localparam logic [15:0] CKSUM_RST = cfg_sum(CFG_RST);

   vps_state_t q;
   vps_state_t d;
   logic signed [15:0] pos, cmd, lo_c, hi_c, thr_c, thr_o;
   logic signed [16:0] lo_rel, hi_rel;
   logic soft_on, lo_en, hi_en, run;

   // ----------------------------------------
   // configuration views
   // ----------------------------------------
   assign pos = $signed(q.s2.pos);
   assign cmd = $signed(q.s2.cmd);
   assign lo_c = $signed(q.cfg[`VPS_C_LOCLAMP]);
   assign hi_c = $signed(q.cfg[`VPS_C_HICLAMP]);
   assign thr_c = $signed(q.cfg[`VPS_C_CLOSE]);
   assign thr_o = $signed(q.cfg[`VPS_C_OPEN]);
   // exit points carry the fixed hysteresis so the valve does not chatter at the seat
   assign lo_rel = thr_c + $signed({1'b0, `VPS_HYS});
   assign hi_rel = thr_o - $signed({1'b0, `VPS_HYS});
   assign soft_on = lo_c > $signed(`VPS_SOFT_LO_TH) || hi_c < $signed(`VPS_FULL);
   assign lo_en = !soft_on && lo_c <= $signed(16'h0000);
   assign hi_en = !soft_on;
   assign run = ce && q.fsm == VPS_RUN;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      logic signed [16:0] dp;
      logic signed [16:0] dv;
      logic signed [16:0] back;
      logic [16:0] mag;
      logic [16:0] dmag;
      logic [32:0] prod;
      logic [32:0] sum;
      logic [15:0] stat;
      logic [31:0] rd;
      logic [7:0] code;
      logic [7:0] shl;
      logic adv;
      logic sel_cfg;
      logic err;
      logic ms;
      logic big;
      d = q;
      dp = pos - $signed(q.db_ctr);
      mag = dp[16] ? 17'(-dp) : 17'(dp);
      prod = mag * q.cfg[`VPS_C_STROKE];
      sum = {1'b0, q.travel} + 33'(prod / 33'(`VPS_TRAVEL_DIV));
      back = q.dir_up ? $signed(q.cyc_ext) - pos : pos - $signed(q.cyc_ext);
      dv = pos - cmd;
      dmag = dv[16] ? 17'(-dv) : 17'(dv);
      big = dmag > {1'b0, q.cfg[`VPS_C_TRIP]};
      ms = q.tick == 24'(TICK_CYC - 1);
      adv = q.cfg[`VPS_C_LEVEL][0];
      stat = {5'h00, q.sat_hi, q.sat_lo, q.deviation, q.cyc_over, q.clamp_hit, q.pos_alert,
              q.bot_alm & adv, q.top_alm & adv, q.p_loss & adv, q.pz_alm, q.cks_alm};
      // one code at a time, internal alarms ahead of user alerts
      if (q.cks_alm)
         code = `VPS_LED_RED;
      else if (q.p_loss)
         code = `VPS_LED_PLOSS;
      else if (q.pz_alm || q.top_alm || q.bot_alm)
         code = `VPS_LED_RED;
      else if (q.deviation)
         code = `VPS_LED_DEV;
      else if (q.cyc_over)
         code = `VPS_LED_CYC;
      else if (q.pos_alert || q.clamp_hit)
         code = `VPS_LED_GREEN;
      else
         code = 8'h00;
      shl = code << {q.step, 1'b0};

      // register decode
      sel_cfg = 1'b0;
      err = 1'b0;
      rd = 32'h0000_0000;
      if (paddr[1:0] != 2'h0)
         err = 1'b1;
      else if (paddr < `VPS_OFF_STAT)
      begin
         sel_cfg = paddr[5:2] < 4'(`VPS_NCFG);
         err = !sel_cfg;
         if (sel_cfg)
            rd = {16'h0000, q.cfg[paddr[5:2]]};
      end
      else if (paddr == `VPS_OFF_STAT)
         rd = {16'h0000, stat};
      else if (paddr == `VPS_OFF_TRAVEL)
         rd = q.travel;
      else if (paddr == `VPS_OFF_CYCLES)
         rd = {16'h0000, q.cycles};
      else if (paddr == `VPS_OFF_PZREAD)
         rd = {16'h0000, q.pz_read};
      else if (paddr == `VPS_OFF_PSENS)
         rd = adv ? {q.s2.top, q.s2.bot} : 32'h0000_0000;
      else if (paddr == `VPS_OFF_SUPPLY)
         rd = adv ? {16'h0000, q.s2.supply} : 32'h0000_0000;
      else if (paddr == `VPS_OFF_CTRL)
         rd = 32'h0000_0000;
      else if (paddr == `VPS_OFF_CKSUM)
         rd = {16'h0000, q.nv_sum};
      else
         err = 1'b1;

      if (ce)
      begin
         // sensor words come from another domain: two flops before use
         d.s1 = sense;
         d.s2 = q.s1;
         d.tick = ms ? 24'h00_0000 : q.tick + 24'h00_0001;
         if (q.stepc == 24'(STEP_CYC - 1))
         begin
            d.stepc = 24'h00_0000;
            d.step = q.step + 2'h1;
         end
         else
            d.stepc = q.stepc + 24'h00_0001;
         d.led.red = shl[7:6] == 2'h1;
         d.led.green = shl[7:6] == 2'h2;
         d.led.yellow = shl[7:6] == 2'h3;

         case (q.fsm)
            VPS_INIT:
            begin
               // lets the sensor synchronisers fill before the band is centred
               d.init_cnt = q.init_cnt + 2'h1;
               if (q.init_cnt == `VPS_INIT_CYC)
                  d.fsm = VPS_CHECK;
            end
            VPS_CHECK:
            begin
               d.cfg = q.nv;
               d.cks_alm = cfg_sum(q.nv) != q.nv_sum;
               d.db_ctr = q.s2.pos;
               d.cyc_ext = q.s2.pos;
               d.fsm = VPS_RUN;
            end
            VPS_RUN:
            begin
               if (!lo_en)
                  d.sat_lo = 1'b0;
               else if (q.sat_lo)
                  d.sat_lo = cmd < lo_rel;
               else
                  d.sat_lo = cmd <= thr_c;
               if (!hi_en)
                  d.sat_hi = 1'b0;
               else if (q.sat_hi)
                  d.sat_hi = cmd > hi_rel;
               else
                  d.sat_hi = cmd >= thr_o;
               if (cmd < lo_c)
               begin
                  d.drv.sp = q.cfg[`VPS_C_LOCLAMP];
                  d.clamp_hit = 1'b1;
               end
               else if (cmd > hi_c)
               begin
                  d.drv.sp = q.cfg[`VPS_C_HICLAMP];
                  d.clamp_hit = 1'b1;
               end
               else
               begin
                  d.drv.sp = q.s2.cmd;
                  d.clamp_hit = 1'b0;
               end
               // close wins if badly configured thresholds overlap
               d.drv.sat_close = d.sat_lo;
               d.drv.sat_open = d.sat_hi && !d.sat_lo;
               d.pos_alert = pos < $signed(q.cfg[`VPS_C_ALO]) || pos > $signed(q.cfg[`VPS_C_AHI]);
               d.pz_alm = q.s2.piezo < q.cfg[`VPS_C_PZMIN] || q.s2.piezo > q.cfg[`VPS_C_PZMAX];
               d.pz_read = q.s2.piezo / `VPS_PZ_SCALE;
               d.p_loss = q.s2.supply < `VPS_PLOSS_TH;
               if (q.s2.cal)
               begin
                  d.top_alm = q.s2.top < `VPS_SENS_MIN || q.s2.top > `VPS_SENS_MAX;
                  d.bot_alm = q.s2.bot < `VPS_SENS_MIN || q.s2.bot > `VPS_SENS_MAX;
               end
               if (mag > {1'b0, q.cfg[`VPS_C_TDB]})
               begin
                  d.travel = sum[32] ? 32'hFFFF_FFFF : sum[31:0];
                  d.db_ctr = q.s2.pos;
               end
               if (back < $signed(17'h0_0000))
                  d.cyc_ext = q.s2.pos;
               else if (back > $signed({1'b0, q.cfg[`VPS_C_CDB]}))
               begin
                  d.cyc_ext = q.s2.pos;
                  d.dir_up = !q.dir_up;
                  if (q.cycles != 16'hFFFF)
                     d.cycles = q.cycles + 16'h0001;
               end
               d.cyc_over = q.cycles > q.cfg[`VPS_C_CYCLIM];
               if (!big)
                  d.dev_ms = 16'h0000;
               else if (ms && q.dev_ms != 16'hFFFF)
                  d.dev_ms = q.dev_ms + 16'h0001;
               d.deviation = big && q.dev_ms > q.cfg[`VPS_C_SETTLE];
            end
            default:
               d.fsm = VPS_INIT;
         endcase

         // apb: data and error latched in setup, write applied at the access edge
         if (psel && penable && q.pready)
         begin
            d.pready = 1'b0;
            d.pslverr = 1'b0;
            if (pwrite && !q.pslverr)
            begin
               if (sel_cfg)
                  d.cfg[paddr[5:2]] = pwdata[15:0];
               else if (paddr == `VPS_OFF_CTRL)
               begin
                  if (pwdata[`VPS_CTRL_STORE])
                  begin
                     d.nv = q.cfg;
                     d.nv_sum = cfg_sum(q.cfg);
                  end
                  if (pwdata[`VPS_CTRL_CHECK])
                     d.fsm = VPS_CHECK;
               end
               else if (paddr == `VPS_OFF_CKSUM)
                  d.nv_sum = pwdata[15:0];
            end
         end
         else if (psel && !penable)
         begin
            d.pready = 1'b1;
            d.pslverr = err;
            d.prdata = rd;
         end
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q <= '0;
         q.cfg <= CFG_RST;
         q.nv <= CFG_RST;
         q.nv_sum <= CKSUM_RST;
      end
      else
         q <= d;
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign drive = q.drv;
   assign led = q.led;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_check_bad;
      ce && q.fsm == VPS_CHECK && cfg_sum(q.nv) != q.nv_sum;
   endsequence

   sequence s_store;
      ce && psel && penable && q.pready && pwrite && !q.pslverr && paddr == `VPS_OFF_CTRL && pwdata[`VPS_CTRL_STORE];
   endsequence

   a_cks_alarm_red:
   assert property (s_check_bad ##1 ce |=> q.cks_alm && led.red)
   else $error("checksum mismatch did not raise red alarm");

   a_store_cksum:
   assert property (s_store |=> q.nv == $past(q.cfg) && q.nv_sum == cfg_sum(q.nv))
   else $error("stored config lacks matching checksum");

   a_piezo_range:
   assert property (run && q.s2.piezo > q.cfg[`VPS_C_PZMAX] |=> q.pz_alm)
   else $error("piezo over range without alarm");

   a_press_loss:
   assert property (run && q.s2.supply < `VPS_PLOSS_TH |=> q.p_loss)
   else $error("low supply pressure without alarm");

   a_close_enter:
   assert property (run && lo_en && cmd <= thr_c |=> drive.sat_close)
   else $error("close threshold reached without saturation");

   a_close_hold:
   assert property (run && lo_en && q.sat_lo && cmd < lo_rel |=> drive.sat_close)
   else $error("saturation left inside hysteresis");

   a_close_exit:
   assert property (run && lo_en && q.sat_lo && cmd >= lo_rel |=> !drive.sat_close)
   else $error("saturation kept past hysteresis");

   a_low_gate:
   assert property (run && lo_c > $signed(16'h0000) |=> !drive.sat_close)
   else $error("low shutoff active with raised lower clamp");

   a_soft_disable:
   assert property (run && soft_on |=> !drive.sat_close && !drive.sat_open)
   else $error("shutoff active while soft stops on");

   a_clamp_low:
   assert property (run && cmd < lo_c |=> $signed(drive.sp) == $past(lo_c) && q.clamp_hit)
   else $error("setpoint not held at lower clamp");

   a_travel_sat:
   assert property (q.travel >= $past(q.travel))
   else $error("travel total wrapped");

endmodule
`default_nettype wire

// >>> inc/vps_defs.svh
// offsets, config indices, reset values, thresholds and timing of the valve position supervisor
`ifndef VPS_DEFS_SVH
`define VPS_DEFS_SVH
`define VPS_NCFG 15
`define VPS_C_CLOSE 4'h0
`define VPS_C_OPEN 4'h1
`define VPS_C_LOCLAMP 4'h2
`define VPS_C_HICLAMP 4'h3
`define VPS_C_ALO 4'h4
`define VPS_C_AHI 4'h5
`define VPS_C_TDB 4'h6
`define VPS_C_CDB 4'h7
`define VPS_C_STROKE 4'h8
`define VPS_C_CYCLIM 4'h9
`define VPS_C_TRIP 4'hA
`define VPS_C_SETTLE 4'hB
`define VPS_C_LEVEL 4'hC
`define VPS_C_PZMIN 4'hD
`define VPS_C_PZMAX 4'hE
// config reset image, index 14 down to 0
`define VPS_CFG_RST {16'h0960, 16'h0064, 16'h0000, 16'h000A, 16'h01F4, 16'hFFFF, 16'h0064, 16'h01F4, \
   16'h07D0, 16'h2AF8, 16'hFC18, 16'h2710, 16'h0000, 16'h2710, 16'h0000}
`define VPS_OFF_STAT 8'h40
`define VPS_OFF_TRAVEL 8'h44
`define VPS_OFF_CYCLES 8'h48
`define VPS_OFF_PZREAD 8'h4C
`define VPS_OFF_PSENS 8'h50
`define VPS_OFF_SUPPLY 8'h54
`define VPS_OFF_CTRL 8'h58
`define VPS_OFF_CKSUM 8'h5C
`define VPS_CTRL_STORE 0
`define VPS_CTRL_CHECK 1
`define VPS_HYS 16'h0064
`define VPS_FULL 16'h2710
`define VPS_SOFT_LO_TH 16'h0BB8
`define VPS_PLOSS_TH 16'h014A
`define VPS_SENS_MIN 16'h0000
`define VPS_SENS_MAX 16'h09C4
`define VPS_PZ_SCALE 16'h000A
`define VPS_TRAVEL_DIV 16'h2710
`define VPS_INIT_CYC 2'h3
`define VPS_LED_RED 8'h55
`define VPS_LED_PLOSS 8'h6D
`define VPS_LED_DEV 8'h65
`define VPS_LED_CYC 8'hAE
`define VPS_LED_GREEN 8'hAA
`define VPS_CLK_NS 100
`define VPS_TICK_NS 1000000
`define VPS_STEP_NS 250000000
`endif

// >>> inc/vps_pkg.sv
// types shared by the valve position supervisor
`include "vps_defs.svh"
package vps_pkg;
   typedef enum logic [1:0] {VPS_INIT = 2'h0, VPS_CHECK = 2'h1, VPS_RUN = 2'h3} vps_fsm_t;
   typedef struct packed {
      logic [15:0] pos;
      logic [15:0] cmd;
      logic [15:0] supply;
      logic [15:0] top;
      logic [15:0] bot;
      logic [15:0] piezo;
      logic cal;
   } vps_sense_t;
   typedef struct packed {
      logic [15:0] sp;
      logic sat_close;
      logic sat_open;
   } vps_drive_t;
   typedef struct packed {
      logic red;
      logic green;
      logic yellow;
   } vps_led_t;
   typedef struct packed {
      vps_fsm_t fsm;
      logic [1:0] init_cnt;
      logic [`VPS_NCFG-1:0][15:0] cfg;
      logic [`VPS_NCFG-1:0][15:0] nv;
      logic [15:0] nv_sum;
      vps_sense_t s1;
      vps_sense_t s2;
      logic cks_alm, pz_alm, p_loss, top_alm, bot_alm, pos_alert, clamp_hit, cyc_over, deviation;
      logic sat_lo, sat_hi, dir_up;
      logic [15:0] db_ctr, cyc_ext, pz_read, cycles, dev_ms;
      logic [31:0] travel;
      logic [23:0] tick, stepc;
      logic [1:0] step;
      logic pready, pslverr;
      logic [31:0] prdata;
      vps_drive_t drv;
      vps_led_t led;
   } vps_state_t;
endpackage

// >>> dv/vps_plant.sv
// plant model: spool-driven stem and pressure/piezo sensors facing the supervisor
`timescale 1ns/1ps
`default_nettype none
module vps_plant (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic stuck,
   input wire logic [15:0] cmd,
   input wire logic [15:0] supply,
   input wire logic [15:0] piezo,
   input wire logic [15:0] top,
   input wire logic cal,
   input wire vps_pkg::vps_drive_t drive,
   output var vps_pkg::vps_sense_t sense
);
   import vps_pkg::*;
   logic [15:0] pos_r;
   // stem follows the setpoint in one step; a stuck stem lets deviation build up
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pos_r <= 16'h1388;
      // an all-zero drive word is what the supervisor shows before it regulates; the stem stays put
      else if (!stuck && drive != '0)
         pos_r <= drive.sat_close ? 16'h0000 : drive.sat_open ? 16'h2710 : drive.sp;
   end
   assign sense = '{pos: pos_r, cmd: cmd, supply: supply, top: top, bot: 16'h01F4, piezo: piezo, cal: cal};
endmodule
`default_nettype wire

// >>> dv/vps_supervisor_tb_top.sv
// self-checking testbench of the valve position supervisor
`timescale 1ns/1ps
`default_nettype none
`include "vps_defs.svh"
module vps_supervisor_tb_top;
   import vps_pkg::*;
   localparam logic [`VPS_NCFG-1:0][15:0] RST = `VPS_CFG_RST;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stuck, cal, ce;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q, c0, trav;
   logic [15:0] cmd, supply, piezo, top, ctr, c;
   logic [2:0] s;
   vps_sense_t sense;
   vps_drive_t drive;
   vps_led_t led;
   int n_mismatch, checked, cyc, seed;
   vps_supervisor #(.TICK_CYC(4), .STEP_CYC(4)) dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sense(sense), .drive(drive), .led(led));
   vps_plant plant (.pclk(pclk), .presetn(presetn), .stuck(stuck), .cmd(cmd), .supply(supply), .piezo(piezo),
      .top(top), .cal(cal), .drive(drive), .sense(sense));
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_mismatch++;
         finish_test();
      end
   end
   task finish_test();
      $display("mismatches %0d, checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // apb master: request held until pready is seen high at a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the bench timeout ends a wait that never sees pready
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      q = pslverr ? 32'hDEAD_BEEF : prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk(q, x);
   endtask
   task st(input int b, input logic x);
      apb(1'b0, `VPS_OFF_STAT, 32'h0000_0000);
      chk(32'(q[b]), 32'(x));
   endtask
   task wt();
      repeat (12) @(posedge pclk);
   endtask
   // moves the command; the bench keeps its own odometer for a stem that follows
   task go(input logic [15:0] cv);
      int d;
      @(posedge pclk);
      cmd <= cv;
      wt();
      d = $signed(cv) - $signed(ctr);
      if (d < 0)
         d = -d;
      if (d > int'(RST[6]))
      begin
         trav = trav + 32'(d * int'(RST[8]) / 10000);
         ctr = cv;
      end
   endtask
   // colours seen over more than one full blink code
   task leds(input logic [2:0] x);
      s = 3'h0;
      repeat (24) @(posedge pclk) s = s | led;
      chk(32'(s), 32'(x));
   endtask
   function automatic logic [15:0] cks();
      logic [15:0] t;
      t = 16'h0000;
      for (int i = 0; i < `VPS_NCFG; i++)
         t = t + RST[i];
      return t;
   endfunction
   initial
   begin
      {psel, penable, pwrite, stuck, cal, presetn} = 6'h00;
      ce = 1'b1;
      {paddr, pwdata} = 40'h00_0000_0000;
      {cmd, supply, piezo, top} = {16'h1388, 16'h0384, 16'h04B0, 16'h01F4};
      seed = 67;
      trav = 32'h0000_0000;
      ctr = 16'h1388;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      for (int i = 0; i < `VPS_NCFG; i++)
         rd(8'(4 * i), 32'(RST[i]));
      rd(8'h3C, 32'hDEAD_BEEF);
      rd(`VPS_OFF_STAT, 32'h0000_0000);
      $display("test reset values done");
      go(16'h1A90);
      go(16'h1F40);
      go(16'h1964);
      go(16'h0BB8);
      rd(`VPS_OFF_TRAVEL, trav);
      apb(1'b0, `VPS_OFF_CYCLES, 32'h0000_0000);
      c0 = q;
      go(16'h1F40);
      go(16'h0BB8);
      rd(`VPS_OFF_CYCLES, c0 + 32'h2);
      rd(`VPS_OFF_TRAVEL, trav);
      apb(1'b1, 8'h24, c0 + 32'h1);
      st(7, 1'b1);
      leds(3'b011);
      apb(1'b1, 8'h24, 32'h0000_FFFF);
      $display("test travel and cycles done");
      apb(1'b1, 8'h14, 32'h0000_1B58);
      go(16'h1F40);
      st(5, 1'b1);
      chk(32'(drive.sp), 32'h0000_1F40);
      leds(3'b010);
      apb(1'b1, 8'h14, 32'h0000_2AF8);
      apb(1'b1, 8'h08, 32'h0000_03E8);
      go(16'h01F4);
      chk(32'(drive.sp), 32'h0000_03E8);
      st(6, 1'b1);
      go(16'hFF9C);
      chk(32'(drive.sat_close), 32'h0);
      apb(1'b1, 8'h08, 32'h0000_0000);
      apb(1'b1, 8'h0C, 32'h0000_2328);
      go(16'h2710);
      chk(32'(drive.sp), 32'h0000_2328);
      chk(32'(drive.sat_open), 32'h0);
      apb(1'b1, 8'h0C, 32'h0000_2710);
      $display("test alerts and clamps done");
      go(16'h0000);
      chk(32'(drive.sat_close), 32'h1);
      go(16'h0063);
      chk(32'(drive.sat_close), 32'h1);
      go(16'h0064);
      chk(32'(drive.sat_close), 32'h0);
      go(16'h2710);
      st(10, 1'b1);
      go(16'h26AD);
      chk(32'(drive.sat_open), 32'h1);
      go(16'h26AC);
      chk(32'(drive.sat_open), 32'h0);
      $display("test shutoff done");
      piezo <= 16'h09C4;
      wt();
      st(1, 1'b1);
      rd(`VPS_OFF_PZREAD, 32'h0000_00FA);
      leds(3'b100);
      piezo <= 16'h0063;
      wt();
      st(1, 1'b1);
      rd(`VPS_OFF_PZREAD, 32'h0000_0009);
      piezo <= 16'h04B0;
      wt();
      st(1, 1'b0);
      supply <= 16'h00C8;
      wt();
      st(2, 1'b0);
      rd(`VPS_OFF_SUPPLY, 32'h0000_0000);
      apb(1'b1, 8'h30, 32'h0000_0001);
      st(2, 1'b1);
      rd(`VPS_OFF_SUPPLY, 32'h0000_00C8);
      leds(3'b111);
      supply <= 16'h0384;
      cal <= 1'b1;
      top <= 16'h0BB8;
      wt();
      cal <= 1'b0;
      wt();
      st(3, 1'b1);
      st(4, 1'b0);
      rd(`VPS_OFF_PSENS, 32'h0BB8_01F4);
      top <= 16'h01F4;
      cal <= 1'b1;
      wt();
      cal <= 1'b0;
      wt();
      st(3, 1'b0);
      apb(1'b1, 8'h30, 32'h0000_0000);
      $display("test piezo and pressure done");
      apb(1'b1, 8'h28, 32'h0000_0258);
      apb(1'b1, `VPS_OFF_CKSUM, 32'h0000_0000);
      apb(1'b1, `VPS_OFF_CTRL, 32'h0000_0002);
      wt();
      st(0, 1'b1);
      leds(3'b100);
      rd(8'h28, 32'h0000_01F4);
      apb(1'b1, 8'h28, 32'h0000_0258);
      apb(1'b1, `VPS_OFF_CTRL, 32'h0000_0001);
      rd(`VPS_OFF_CKSUM, 32'(cks() + 16'h0064));
      apb(1'b1, `VPS_OFF_CTRL, 32'h0000_0002);
      wt();
      st(0, 1'b0);
      rd(8'h28, 32'h0000_0258);
      $display("test checksum done");
      stuck <= 1'b1;
      go(16'h07D0);
      st(8, 1'b0);
      repeat (60) @(posedge pclk);
      st(8, 1'b1);
      leds(3'b110);
      stuck <= 1'b0;
      wt();
      st(8, 1'b0);
      $display("test deviation done");
      repeat (16)
      begin
         c = 16'h03E8 + 16'($unsigned($random(seed)) % 8000);
         go(c);
         chk(32'(drive.sp), 32'(c));
         chk(32'({drive.sat_close, drive.sat_open}), 32'h0);
      end
      $display("test random commands done");
      // with the enable low nothing may move, not even the sensor synchronisers
      ce <= 1'b0;
      go(16'h1388);
      chk(32'(drive.sp), 32'(c));
      ce <= 1'b1;
      wt();
      chk(32'(drive.sp), 32'h0000_1388);
      $display("test clock enable done");
      finish_test();
   end
endmodule
`default_nettype wire
